/* File: rtl/arcr_defs.svh */
/*
 result register offsets, field positions, reset values and interrupt
 register offsets for the result channel block.
 assumes inclusion by bare name; definitions only.
*/
`ifndef ARCR_DEFS_SVH
`define ARCR_DEFS_SVH
`define ARCR_OFS_CH6 12'h088
`define ARCR_OFS_CH7 12'h08c
`define ARCR_OFS_CH8 12'h090
`define ARCR_OFS_CH9 12'h094
`define ARCR_OFS_CH10 12'h098
`define ARCR_OFS_CH11 12'h09c
`define ARCR_OFS_CH12 12'h110
`define ARCR_OFS_IRQ_STAT 12'h200
`define ARCR_OFS_IRQ_MASK 12'h204
`define ARCR_OFS_FILT_EN 12'h208
`define ARCR_BIT_WFR 16
`define ARCR_BIT_VF 17
`define ARCR_BIT_OF 18
`define ARCR_VAL_MSB 11
`define ARCR_NCH 7
`define ARCR_RST_VAL 12'h000
`define ARCR_RST_VAL_HI 2'h0
`define ARCR_RST_FLAG 1'b0
`define ARCR_RST_MASK 14'h0000
`define ARCR_RST_FILT_EN 7'h7f
`endif

/* File: rtl/arcr_pkg.sv */
/*
 types shared by the result channel block.
 assumes nothing beyond a systemverilog compiler.
*/
package arcr_pkg;
    typedef logic [11:0] arcr_value_t;
    typedef enum logic [0:0] {
        ARCR_OVERWRITE,
        ARCR_WAIT_FOR_READ
    } arcr_mode_t;
    typedef enum {
        ARCR_BUS_IDLE,
        ARCR_BUS_ACK
    } arcr_bus_state_t;
endpackage : arcr_pkg

/* File: rtl/arcr_channel.sv */
/*
 one result register channel: value, valid flag, overrun flag, mode bit.
 assumes update and read strobes are one-cycle pulses on clk.
*/
`timescale 1ns/1ps
`include "arcr_defs.svh"
module arcr_channel (
    input wire logic clk,
    input wire logic rst,
    input wire logic upd,
    input wire arcr_pkg::arcr_value_t upd_val,
    input wire logic sw_mode,
    input wire logic rd,
    input wire logic mode_we,
    input wire logic mode_wdata,
    output logic [31:0] word,
    output logic ev_new,
    output logic ev_ovr
);
    arcr_pkg::arcr_value_t value_reg;
    logic valid_flag_reg;
    logic overrun_flag_reg;
    arcr_pkg::arcr_mode_t mode_reg;
    logic take;

    // wait-for-read holds the stored value until it is read
    assign take = upd && !(mode_reg == arcr_pkg::ARCR_WAIT_FOR_READ
                           && valid_flag_reg); // [R12]

    // low ten result bits keep whatever they held across reset
    always_ff @(posedge clk) begin
        if (rst) begin
            value_reg[`ARCR_VAL_MSB:`ARCR_VAL_MSB-1] <=
                `ARCR_RST_VAL_HI; // [R11]
        end else if (take) begin
            value_reg <= upd_val; // [R1]
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            valid_flag_reg <= `ARCR_RST_FLAG; // [R11]
        end else if (take) begin
            valid_flag_reg <= 1'b1; // [R3] [R5]
        end else if (rd) begin
            valid_flag_reg <= 1'b0; // [R4]
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            overrun_flag_reg <= `ARCR_RST_FLAG; // [R11]
        end else if (take && valid_flag_reg && !sw_mode
                     && mode_reg == arcr_pkg::ARCR_OVERWRITE) begin
            overrun_flag_reg <= 1'b1; // [R6] [R7]
        end else if (rd) begin
            overrun_flag_reg <= 1'b0; // [R8]
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            mode_reg <= arcr_pkg::ARCR_OVERWRITE; // [R11]
        end else if (mode_we) begin
            mode_reg <= arcr_pkg::arcr_mode_t'(mode_wdata); // [R9]
        end
    end

    always_comb begin
        word = 32'h0000_0000; // [R10]
        word[`ARCR_VAL_MSB:0] = value_reg; // [R1]
        word[`ARCR_BIT_WFR] = (mode_reg == arcr_pkg::ARCR_WAIT_FOR_READ);
        word[`ARCR_BIT_VF] = valid_flag_reg;
        word[`ARCR_BIT_OF] = overrun_flag_reg;
    end

    assign ev_new = take;
    assign ev_ovr = take && valid_flag_reg && !sw_mode
                    && mode_reg == arcr_pkg::ARCR_OVERWRITE;

    a_valid_set: assert property (@(posedge clk) disable iff (rst)
        take |=> valid_flag_reg) // [R3]
        else $error("valid flag not set after update");
    a_read_clears: assert property (@(posedge clk) disable iff (rst)
        rd && !take |=> !valid_flag_reg && !overrun_flag_reg) // [R4]
        else $error("read did not clear flags");
    a_ovr_cause: assert property (@(posedge clk) disable iff (rst)
        $rose(overrun_flag_reg) |-> $past(valid_flag_reg)
            && $past(mode_reg) == arcr_pkg::ARCR_OVERWRITE
            && !$past(sw_mode)) // [R7]
        else $error("overrun set without cause");
    a_wfr_hold: assert property (@(posedge clk) disable iff (rst)
        upd && valid_flag_reg && mode_reg == arcr_pkg::ARCR_WAIT_FOR_READ
        |=> $stable(value_reg)) // [R12]
        else $error("stored value replaced in wait mode");
endmodule : arcr_channel

/* File: rtl/arcr_irq.sv */
/*
 sticky interrupt status with write-one-to-clear and a mask.
 assumes event inputs are one-cycle pulses on clk.
*/
`timescale 1ns/1ps
`include "arcr_defs.svh"
module arcr_irq (
    input wire logic clk,
    input wire logic rst,
    input wire logic [13:0] events,
    input wire logic stat_we,
    input wire logic mask_we,
    input wire logic [13:0] wdata,
    output logic [13:0] stat,
    output logic [13:0] mask,
    output logic irq
);
    always_ff @(posedge clk) begin
        if (rst) begin
            stat <= `ARCR_RST_MASK;
        end else begin
            // set wins over a simultaneous clear
            stat <= (stat & ~(stat_we ? wdata : 14'h0000)) | events;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            mask <= `ARCR_RST_MASK;
        end else if (mask_we) begin
            mask <= wdata;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            irq <= 1'b0;
        end else begin
            irq <= |(((stat & ~(stat_we ? wdata : 14'h0000)) | events)
                     & (mask_we ? wdata : mask));
        end
    end
endmodule : arcr_irq

/* File: rtl/arcr_top.sv */
/*
 result registers for channels 6 to 12 behind a classic wishbone slave.
 assumes the converter chain pulses res_valid for one cycle per result.
*/
// The Wishbone register port was left to the implementer.
// What this block does
// [R1] low twelve bits show the latest result, read-only to software
// [R2] software clears a filter enable to see the raw converter result
// [R3] hardware update sets the valid flag at bit 17
// [R4] reading a result register clears its valid flag
// [R5] an update taken in the same cycle as a read leaves valid set
// [R6] overrun flag bit 18 sets when an update finds valid set
// [R7] overrun only in overwrite mode and outside software mode
// [R8] reading a result register clears its overrun flag
// [R9] bit 16 selects overwrite (0) or wait-for-read (1) mode
// [R10] bits 31:19 and 15:12 read as zero
// [R11] reset clears flags, mode and result bits 11:10; result bits 9:0 are undefined
// [R12] in wait-for-read mode a valid value is not replaced
`timescale 1ns/1ps
`include "arcr_defs.svh"
module arcr_top (
    input wire logic clk,
    input wire logic rst,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [11:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    input wire logic [6:0] res_valid,
    input wire logic [83:0] filter_result,
    input wire logic [83:0] converter_result,
    input wire logic [6:0] software_mode,
    output logic [6:0] filter_update_enable,
    output logic irq_o
);
    localparam int NCH = `ARCR_NCH;

    arcr_pkg::arcr_bus_state_t bus_state_reg;
    logic [31:0] words [NCH];
    logic [NCH-1:0] rd_stb;
    logic [NCH-1:0] mode_we;
    logic [NCH-1:0] ev_new;
    logic [NCH-1:0] ev_ovr;
    logic [13:0] irq_stat;
    logic [13:0] irq_mask;
    logic irq_next;
    logic access;
    logic [2:0] sel_ch;
    logic hit_ch;
    logic [3:0] ch_dec;
    logic [31:0] rdata_next;

    // channel index for an address, with a hit flag in bit 3
    function automatic logic [3:0] ch_decode(input logic [11:0] a);
        case (a)
            `ARCR_OFS_CH6: ch_decode = 4'h8;
            `ARCR_OFS_CH7: ch_decode = 4'h9;
            `ARCR_OFS_CH8: ch_decode = 4'ha;
            `ARCR_OFS_CH9: ch_decode = 4'hb;
            `ARCR_OFS_CH10: ch_decode = 4'hc;
            `ARCR_OFS_CH11: ch_decode = 4'hd;
            `ARCR_OFS_CH12: ch_decode = 4'he;
            default: ch_decode = 4'h0;
        endcase
    endfunction : ch_decode

    // a request is taken once; ack drops in the following cycle
    assign access = wb_cyc_i && wb_stb_i
                    && bus_state_reg == arcr_pkg::ARCR_BUS_IDLE;
    assign ch_dec = ch_decode(wb_adr_i);
    assign hit_ch = ch_dec[3];
    assign sel_ch = ch_dec[2:0];

    always_ff @(posedge clk) begin
        if (rst) begin
            bus_state_reg <= arcr_pkg::ARCR_BUS_IDLE;
        end else begin
            case (bus_state_reg)
                arcr_pkg::ARCR_BUS_IDLE:
                    if (access) begin
                        bus_state_reg <= arcr_pkg::ARCR_BUS_ACK;
                    end
                arcr_pkg::ARCR_BUS_ACK:
                    bus_state_reg <= arcr_pkg::ARCR_BUS_IDLE;
                default:
                    bus_state_reg <= arcr_pkg::ARCR_BUS_IDLE;
            endcase
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            wb_ack_o <= 1'b0;
        end else begin
            wb_ack_o <= access;
        end
    end

    // mode bit sits in byte lane 2
    always_comb begin
        rd_stb = '0;
        mode_we = '0;
        if (access && hit_ch) begin
            if (wb_we_i) begin
                mode_we[sel_ch] = wb_sel_i[2]; // [R9]
            end else begin
                rd_stb[sel_ch] = 1'b1; // [R4] [R8]
            end
        end
    end

    always_comb begin
        rdata_next = 32'h0000_0000;
        if (hit_ch) begin
            rdata_next = words[sel_ch];
        end else begin
            case (wb_adr_i)
                `ARCR_OFS_IRQ_STAT: rdata_next = {18'h00000, irq_stat};
                `ARCR_OFS_IRQ_MASK: rdata_next = {18'h00000, irq_mask};
                `ARCR_OFS_FILT_EN:
                    rdata_next = {25'h0000000, filter_update_enable};
                default: rdata_next = 32'h0000_0000;
            endcase
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            wb_dat_o <= 32'h0000_0000;
        end else if (access && !wb_we_i) begin
            wb_dat_o <= rdata_next;
        end
    end

    // raw converter words pass when a channel's filter enable is cleared
    always_ff @(posedge clk) begin
        if (rst) begin
            filter_update_enable <= `ARCR_RST_FILT_EN;
        end else if (access && wb_we_i && wb_sel_i[0]
                     && wb_adr_i == `ARCR_OFS_FILT_EN) begin
            filter_update_enable <= wb_dat_i[6:0]; // [R2]
        end
    end

    for (genvar i = 0; i < NCH; i++) begin : g_ch
        arcr_channel u_ch (
            .clk(clk),
            .rst(rst),
            .upd(res_valid[i]),
            .upd_val(filter_update_enable[i]
                     ? filter_result[i*12 +: 12]
                     : converter_result[i*12 +: 12]), // [R2]
            .sw_mode(software_mode[i]),
            .rd(rd_stb[i]),
            .mode_we(mode_we[i]),
            .mode_wdata(wb_dat_i[`ARCR_BIT_WFR]),
            .word(words[i]),
            .ev_new(ev_new[i]),
            .ev_ovr(ev_ovr[i])
        );
    end

    arcr_irq u_irq (
        .clk(clk),
        .rst(rst),
        .events({ev_ovr, ev_new}),
        .stat_we(access && wb_we_i && wb_adr_i == `ARCR_OFS_IRQ_STAT),
        .mask_we(access && wb_we_i && wb_adr_i == `ARCR_OFS_IRQ_MASK),
        .wdata(wb_dat_i[13:0]),
        .stat(irq_stat),
        .mask(irq_mask),
        .irq(irq_next)
    );

    always_ff @(posedge clk) begin
        if (rst) begin
            irq_o <= 1'b0;
        end else begin
            irq_o <= irq_next;
        end
    end

    a_ack_one_cycle: assert property (@(posedge clk) disable iff (rst)
        wb_ack_o |=> !wb_ack_o)
        else $error("ack held longer than one cycle");
    a_ack_follows: assert property (@(posedge clk) disable iff (rst)
        wb_cyc_i && wb_stb_i && !wb_ack_o && !$past(wb_ack_o) |=> wb_ack_o)
        else $error("request not acknowledged next cycle");
    a_res_zero: assert property (@(posedge clk) disable iff (rst)
        wb_ack_o && $past(hit_ch && !wb_we_i)
        |-> wb_dat_o[31:19] == 13'h0000 && wb_dat_o[15:12] == 4'h0) // [R10]
        else $error("reserved bits not zero");
    a_update_wins: assert property (@(posedge clk) disable iff (rst)
        rd_stb[0] && res_valid[0] && !(words[0][`ARCR_BIT_VF]
        && words[0][`ARCR_BIT_WFR]) |=> words[0][`ARCR_BIT_VF]) // [R5]
        else $error("read beat simultaneous update");
    a_ovr_sets: assert property (@(posedge clk) disable iff (rst)
        res_valid[0] && words[0][`ARCR_BIT_VF] && !software_mode[0]
        && !words[0][`ARCR_BIT_WFR] |=> words[0][`ARCR_BIT_OF]) // [R6]
        else $error("overrun not flagged");
    a_reset_clear: assert property (@(posedge clk) disable iff (rst)
        $past(rst) |-> words[0][31:10] == 22'h000000) // [R11]
        else $error("flags not cleared by reset");

    // named steps of a bus transfer, shared by the register checks
    sequence s_read_taken;
        access && !wb_we_i;
    endsequence

    sequence s_write_taken;
        access && wb_we_i;
    endsequence

    sequence s_filt_write;
        s_write_taken ##0 (wb_sel_i[0] && wb_adr_i == `ARCR_OFS_FILT_EN);
    endsequence

    a_ack_has_req: assert property (@(posedge clk) disable iff (rst)
        wb_ack_o |-> $past(wb_cyc_i && wb_stb_i))
        else $error("ack without a request");

    a_unmapped_zero: assert property (@(posedge clk) disable iff (rst)
        s_read_taken ##0 (!hit_ch && wb_adr_i != `ARCR_OFS_IRQ_STAT
            && wb_adr_i != `ARCR_OFS_IRQ_MASK
            && wb_adr_i != `ARCR_OFS_FILT_EN)
        |=> wb_dat_o == 32'h0000_0000)
        else $error("unmapped read not zero");

    a_write_quiet: assert property (@(posedge clk) disable iff (rst)
        s_write_taken |=> $stable(wb_dat_o))
        else $error("read data changed on a write");

    a_filt_write: assert property (@(posedge clk) disable iff (rst)
        s_filt_write |=> filter_update_enable == $past(wb_dat_i[6:0])) // [R2]
        else $error("filter enable not written");

    a_filt_kept: assert property (@(posedge clk) disable iff (rst)
        !(access && wb_we_i && wb_sel_i[0] && wb_adr_i == `ARCR_OFS_FILT_EN)
        |=> $stable(filter_update_enable))
        else $error("filter enable changed without a write");

    // irq_o trails the status and mask by one register stage
    a_irq_level: assert property (@(posedge clk) disable iff (rst)
        !$past(rst) |-> irq_o == $past(|(irq_stat & irq_mask)))
        else $error("interrupt level does not follow status");

    // every channel, seen through the word that software reads
    for (genvar k = 0; k < NCH; k++) begin : g_chk
        sequence s_fresh;
            res_valid[k] && !(words[k][`ARCR_BIT_WFR]
                              && words[k][`ARCR_BIT_VF]);
        endsequence

        sequence s_plain_read;
            rd_stb[k] && !res_valid[k];
        endsequence

        a_value_stored: assert property (@(posedge clk) disable iff (rst)
            s_fresh |=> words[k][`ARCR_VAL_MSB:0]
                == $past(filter_update_enable[k]
                         ? filter_result[k*12 +: 12]
                         : converter_result[k*12 +: 12])) // [R1]
            else $error("new result not stored");

        a_valid_marks: assert property (@(posedge clk) disable iff (rst)
            s_fresh |=> words[k][`ARCR_BIT_VF]) // [R3]
            else $error("valid flag not raised");

        a_late_wins: assert property (@(posedge clk) disable iff (rst)
            s_fresh ##0 rd_stb[k] |=> words[k][`ARCR_BIT_VF]) // [R5]
            else $error("read beat a same-cycle update");

        a_read_empties: assert property (@(posedge clk) disable iff (rst)
            s_plain_read |=> !words[k][`ARCR_BIT_VF]
                && !words[k][`ARCR_BIT_OF]) // [R4] [R8]
            else $error("read left a flag set");

        a_ovr_rule: assert property (@(posedge clk) disable iff (rst)
            $rose(words[k][`ARCR_BIT_OF]) |-> !$past(software_mode[k])
                && !$past(words[k][`ARCR_BIT_WFR])) // [R7]
            else $error("overrun set outside overwrite mode");

        a_mode_stored: assert property (@(posedge clk) disable iff (rst)
            mode_we[k] |=> words[k][`ARCR_BIT_WFR]
                == $past(wb_dat_i[`ARCR_BIT_WFR])) // [R9]
            else $error("mode bit not written");

        a_mode_kept: assert property (@(posedge clk) disable iff (rst)
            !mode_we[k] |=> $stable(words[k][`ARCR_BIT_WFR])) // [R9]
            else $error("mode bit changed without a write");

        a_rsvd_clear: assert property (@(posedge clk) disable iff (rst)
            words[k][31:19] == 13'h0000 && words[k][15:12] == 4'h0) // [R10]
            else $error("reserved bits set");

        a_wait_keeps: assert property (@(posedge clk) disable iff (rst)
            res_valid[k] && words[k][`ARCR_BIT_WFR] && words[k][`ARCR_BIT_VF]
            |=> $stable(words[k][`ARCR_VAL_MSB:0])) // [R12]
            else $error("held result replaced");

        a_reset_empty: assert property (@(posedge clk) disable iff (rst)
            $past(rst) |-> words[k][31:10] == 22'h000000) // [R11]
            else $error("register not cleared by reset");
    end
endmodule : arcr_top

/* File: tb/arcr_top_test.sv */
/*
 self-checking bench for the result channel block: wishbone reads and
 writes, result updates, flags, modes, filter select and interrupt.
 assumes the design files under rtl/ and a 40 MHz single clock.
*/
`timescale 1ns/1ps
`include "arcr_defs.svh"
`define CHK(a, b) begin n_tests++; if ((a) !== (b)) begin error_cnt++; \
    $display("BAD t=%0t got=%h exp=%h", $time, a, b); end end
module arcr_top_test;
    logic clk, rst, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o, irq_o;
    logic [11:0] wb_adr_i;
    logic [3:0] wb_sel_i;
    logic [31:0] wb_dat_i, wb_dat_o, q;
    logic [6:0] res_valid, software_mode, filter_update_enable;
    logic [83:0] filter_result, converter_result;
    logic [31:0] seed;
    logic [11:0] va, vb, vc;
    logic [3:0] wsel;
    int error_cnt, n_tests;
    arcr_top uut (.clk(clk), .rst(rst), .wb_cyc_i(wb_cyc_i),
        .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
        .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
        .wb_ack_o(wb_ack_o), .res_valid(res_valid),
        .filter_result(filter_result), .converter_result(converter_result),
        .software_mode(software_mode),
        .filter_update_enable(filter_update_enable), .irq_o(irq_o));
    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end
    function automatic logic [11:0] rnd();
        seed = {seed[30:0], 1'b0} ^ (seed[31] ? 32'h00400007 : 32'h0);
        return seed[11:0];
    endfunction : rnd
    function automatic logic [31:0] exp_word(logic [11:0] v, logic ovr,
        logic vld, logic wfr);
        return {13'h0000, ovr, vld, wfr, 4'h0, v};
    endfunction : exp_word
    function automatic logic [11:0] ofs(int i);
        case (i)
            0: ofs = `ARCR_OFS_CH6;
            1: ofs = `ARCR_OFS_CH7;
            2: ofs = `ARCR_OFS_CH8;
            3: ofs = `ARCR_OFS_CH9;
            4: ofs = `ARCR_OFS_CH10;
            5: ofs = `ARCR_OFS_CH11;
            default: ofs = `ARCR_OFS_CH12;
        endcase
    endfunction : ofs
    task automatic tally_and_finish();
        $display("comparisons %0d mismatches %0d", n_tests, error_cnt);
        if (error_cnt == 0 && n_tests > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask : tally_and_finish
    // up pulses res_valid in the cycle the request is taken
    task automatic wb(input logic we, input logic [11:0] a,
        input logic [31:0] d, input logic [6:0] up, output logic [31:0] r);
        int n;
        @(posedge clk);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i <= we;
        wb_adr_i <= a;
        wb_dat_i <= d;
        wb_sel_i <= wsel;
        res_valid <= up;
        for (n = 0; n < 20; n++) begin
            @(posedge clk);
            res_valid <= 7'h00;
            if (wb_ack_o === 1'b1) break;
        end
        r = wb_dat_o;
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
        wb_we_i <= 1'b0;
        if (n == 20) begin
            error_cnt++;
            tally_and_finish();
        end
    endtask : wb
    task automatic rd(input logic [11:0] a);
        wb(1'b0, a, 32'h0, 7'h00, q);
    endtask : rd
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        logic [31:0] dummy;
        wb(1'b1, a, d, 7'h00, dummy);
    endtask : wr
    // raw path gets the inverse so a wrong source is visible
    task automatic upd(input int ch, input logic [11:0] v);
        @(posedge clk);
        filter_result[ch*12 +: 12] <= v;
        converter_result[ch*12 +: 12] <= ~v;
        res_valid[ch] <= 1'b1;
        @(posedge clk);
        res_valid <= 7'h00;
    endtask : upd
    initial begin
        seed = 32'hffed;
        wsel = 4'hf;
        {wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_sel_i} = '0;
        {wb_dat_i, res_valid, software_mode} = '0;
        filter_result = '0;
        converter_result = '0;
        rst = 1'b1;
        repeat (3) @(posedge clk);
        rst <= 1'b0;
        rd(ofs(1));
        `CHK(q[31:10], 22'h000000)
        rd(`ARCR_OFS_FILT_EN);
        `CHK(q[6:0], 7'h7f)
        rd(12'h300);
        `CHK(q, 32'h00000000)
        for (int i = 0; i < 7; i++) begin
            va = rnd();
            vb = rnd();
            upd(i, va);
            rd(ofs(i));
            `CHK(q, exp_word(va, 1'b0, 1'b1, 1'b0))
            rd(ofs(i));
            `CHK(q, exp_word(va, 1'b0, 1'b0, 1'b0))
            upd(i, va);
            upd(i, vb);
            rd(ofs(i));
            `CHK(q, exp_word(vb, 1'b1, 1'b1, 1'b0))
            rd(ofs(i));
            `CHK(q, exp_word(vb, 1'b0, 1'b0, 1'b0))
        end
        software_mode <= 7'h01;
        upd(0, va);
        upd(0, vb);
        rd(ofs(0));
        `CHK(q, exp_word(vb, 1'b0, 1'b1, 1'b0))
        software_mode <= 7'h00;
        vc = rnd();
        upd(0, va);
        filter_result[11:0] <= vc;
        wb(1'b0, ofs(0), 32'h0, 7'h01, q);
        `CHK(q, exp_word(va, 1'b0, 1'b1, 1'b0))
        rd(ofs(0));
        `CHK(q, exp_word(vc, 1'b1, 1'b1, 1'b0))
        wr(ofs(0), 32'hffff_ffff);
        rd(ofs(0));
        `CHK(q, exp_word(vc, 1'b0, 1'b0, 1'b1))
        upd(0, va);
        upd(0, vb);
        rd(ofs(0));
        `CHK(q, exp_word(va, 1'b0, 1'b1, 1'b1))
        wr(ofs(0), 32'h0);
        // mode bit lives in lane 2; a write without that lane leaves it
        wsel = 4'hb;
        wr(ofs(2), 32'h0001_0000);
        wsel = 4'hf;
        rd(ofs(2));
        `CHK(q[`ARCR_BIT_WFR], 1'b0)
        wr(`ARCR_OFS_FILT_EN, 32'h0000_007e);
        `CHK(filter_update_enable, 7'h7e)
        upd(0, va);
        rd(ofs(0));
        `CHK(q, exp_word(~va, 1'b0, 1'b1, 1'b0))
        wr(`ARCR_OFS_FILT_EN, 32'h0000_007f);
        wr(`ARCR_OFS_IRQ_STAT, 32'h0000_3fff);
        wr(`ARCR_OFS_IRQ_MASK, 32'h0);
        upd(1, va);
        rd(`ARCR_OFS_IRQ_STAT);
        `CHK(q[13:0], 14'h0002)
        `CHK(irq_o, 1'b0)
        wr(`ARCR_OFS_IRQ_MASK, 32'h0000_0002);
        repeat (2) @(posedge clk);
        `CHK(irq_o, 1'b1)
        wr(`ARCR_OFS_IRQ_STAT, 32'h0000_0002);
        repeat (2) @(posedge clk);
        `CHK(irq_o, 1'b0)
        upd(1, vb);
        rd(`ARCR_OFS_IRQ_STAT);
        `CHK(q[13:0], 14'h0102)
        `CHK(irq_o, 1'b1)
        // second reset in mid-run with a pending flag and mode set
        wr(ofs(1), 32'h0001_0000);
        rst <= 1'b1;
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        rd(ofs(1));
        `CHK(q[31:10], 22'h000000)
        `CHK(irq_o, 1'b0)
        tally_and_finish();
    end
endmodule : arcr_top_test
